//--- design/blp_pkg.sv
// Package with register map, field layout and constants of the backlight PWM generator.
package blp_pkg;

    localparam logic [3:0] BLP_OFF_PIN_CTL = 4'h0;
    localparam logic [3:0] BLP_OFF_DATA = 4'h4;
    localparam logic [3:0] BLP_OFF_MOD_CTL = 4'h8;
    localparam logic [3:0] BLP_OFF_STATUS = 4'hc;

    localparam int BLP_PIN_EN_BIT = 31;
    localparam int BLP_PIN_POL_BIT = 22;
    localparam int BLP_PIN_MODE_LSB = 24;
    localparam int BLP_MOD_EN_BIT = 31;
    localparam int BLP_MOD_GRAN_BIT = 30;
    localparam int BLP_FREQ_LSB = 16;

    localparam logic [2:0] BLP_MODE_PWM = 3'h1;
    localparam logic [31:0] BLP_PIN_CTL_RST = 32'h0000_0000;
    localparam logic [31:0] BLP_DATA_RST = 32'h0000_0000;
    localparam logic [1:0] BLP_MOD_CTL_RST = 2'h0;

    localparam logic [7:0] BLP_INC_COARSE = 8'h80;
    localparam logic [7:0] BLP_INC_FINE = 8'h08;

    typedef enum logic [1:0] {
        BLP_IDLE = 2'b00,
        BLP_ACTIVE = 2'b01,
        BLP_INACTIVE = 2'b11
    } blp_phase_e;

    typedef struct packed {
        logic pin_en;
        logic [2:0] pin_mode;
        logic pin_pol;
    } blp_pin_s;

    typedef struct packed {
        logic [15:0] freq;
        logic [15:0] duty;
    } blp_data_s;

endpackage

//--- design/blp_top.sv
// Backlight PWM generator with a classic Wishbone register slave.
//
// Function
// - Output frequency is clock over increment over divider.
// - Runs on the display core clock, roughly 308.57 to 675 MHz.
// - Software picks an increment of 128 or 8 clocks per step.
// - Divider values reach up to two to the sixteenth.
// - Utility pin has enable, function selector with PWM mode and polarity.
// - Duty updates are accepted while the output runs.
// - Granularity and polarity may be written before the final enable.
//
// The Wishbone slave port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module blp_top
    import blp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic util_pin_o,
    output logic util_pin_oe
);

    blp_pin_s pin_reg;
    blp_data_s data_reg;
    blp_data_s live_reg;
    logic mod_en_reg;
    logic gran_reg;
    logic [7:0] step_cnt_reg;
    logic [16:0] per_cnt_reg;
    blp_phase_e phase_reg;
    logic [31:0] rd_next;
    logic wb_req;
    logic step_last;
    logic per_last;
    logic [16:0] period_len;
    logic level_next;

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    // Writes take effect on the cycle the request is seen; byte lane 3 holds the control bits, except the pin polarity in lane 2.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_reg <= blp_pin_s'(5'h00);
            data_reg <= blp_data_s'(BLP_DATA_RST);
            mod_en_reg <= BLP_MOD_CTL_RST[1];
            gran_reg <= BLP_MOD_CTL_RST[0];
        end else if (wb_req && wb_we_i) begin
            case (wb_adr_i)
                BLP_OFF_PIN_CTL: begin
                    if (wb_sel_i[3]) begin
                        pin_reg.pin_en <= wb_dat_i[BLP_PIN_EN_BIT];
                        pin_reg.pin_mode <= wb_dat_i[BLP_PIN_MODE_LSB +: 3];
                    end
                    if (wb_sel_i[2]) begin
                        pin_reg.pin_pol <= wb_dat_i[BLP_PIN_POL_BIT];
                    end
                end
                BLP_OFF_DATA: begin
                    if (wb_sel_i[3]) data_reg.freq[15:8] <= wb_dat_i[31:24];
                    if (wb_sel_i[2]) data_reg.freq[7:0] <= wb_dat_i[23:16];
                    if (wb_sel_i[1]) data_reg.duty[15:8] <= wb_dat_i[15:8];
                    if (wb_sel_i[0]) data_reg.duty[7:0] <= wb_dat_i[7:0];
                end
                BLP_OFF_MOD_CTL: begin
                    if (wb_sel_i[3]) begin
                        mod_en_reg <= wb_dat_i[BLP_MOD_EN_BIT];
                        gran_reg <= wb_dat_i[BLP_MOD_GRAN_BIT];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        rd_next = 32'h0000_0000;
        case (wb_adr_i)
            BLP_OFF_PIN_CTL: begin
                rd_next[BLP_PIN_EN_BIT] = pin_reg.pin_en;
                rd_next[BLP_PIN_MODE_LSB +: 3] = pin_reg.pin_mode;
                rd_next[BLP_PIN_POL_BIT] = pin_reg.pin_pol;
            end
            BLP_OFF_DATA: rd_next = data_reg;
            BLP_OFF_MOD_CTL: begin
                rd_next[BLP_MOD_EN_BIT] = mod_en_reg;
                rd_next[BLP_MOD_GRAN_BIT] = gran_reg;
            end
            BLP_OFF_STATUS: begin
                rd_next[31] = util_pin_o;
                rd_next[30] = (phase_reg == BLP_ACTIVE);
                rd_next[16:0] = per_cnt_reg;
            end
            default: rd_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_req && !wb_we_i) begin
            wb_dat_o <= rd_next;
        end
    end

    // A divider field of zero stands for the full 2^16 steps.
    assign period_len = (live_reg.freq == 16'h0000) ? 17'h10000 : {1'b0, live_reg.freq};
    assign step_last = (step_cnt_reg == ((gran_reg ? BLP_INC_FINE : BLP_INC_COARSE) - 8'h01));
    assign per_last = step_last && (per_cnt_reg == period_len - 17'h00001);

    // Step prescaler and period counter; the pair divides the core clock twice.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            step_cnt_reg <= 8'h00;
            per_cnt_reg <= 17'h00000;
        end else if (!mod_en_reg) begin
            step_cnt_reg <= 8'h00;
            per_cnt_reg <= 17'h00000;
        end else if (step_last) begin
            step_cnt_reg <= 8'h00;
            per_cnt_reg <= per_last ? 17'h00000 : per_cnt_reg + 17'h00001;
        end else begin
            step_cnt_reg <= step_cnt_reg + 8'h01;
        end
    end

    // Divider and duty load on every clock while disabled and at every period boundary while enabled.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            live_reg <= blp_data_s'(BLP_DATA_RST);
        end else if (!mod_en_reg || per_last) begin
            live_reg <= data_reg;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_reg <= BLP_IDLE;
        end else if (!mod_en_reg) begin
            phase_reg <= BLP_IDLE;
        end else begin
            // Phase tracks the unpolarised level that the pin shows next.
            case (phase_reg)
                BLP_IDLE: phase_reg <= level_next ? BLP_ACTIVE : BLP_INACTIVE;
                BLP_ACTIVE: phase_reg <= level_next ? BLP_ACTIVE : BLP_INACTIVE;
                BLP_INACTIVE: phase_reg <= level_next ? BLP_ACTIVE : BLP_INACTIVE;
                default: phase_reg <= BLP_IDLE;
            endcase
        end
    end

    // Active while the period count is below the duty; polarity inverts the pin.
    always_comb begin
        level_next = 1'b0;
        if (mod_en_reg && pin_reg.pin_mode == BLP_MODE_PWM) begin
            level_next = ({1'b0, live_reg.duty} > per_cnt_reg);
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            util_pin_o <= 1'b0;
            util_pin_oe <= 1'b0;
        end else begin
            util_pin_o <= level_next ^ pin_reg.pin_pol;
            util_pin_oe <= pin_reg.pin_en;
        end
    end

    // The pin lags its inputs by one register, so the polarity is taken one cycle back.
    property p_inactive_when_off;
        @(posedge sys_clk) disable iff (!reset_n)
        $past(!mod_en_reg) |-> util_pin_o == $past(pin_reg.pin_pol);
    endproperty
    a_inactive_when_off: assert property (p_inactive_when_off)
        else $error("pin not inactive while disabled");
    property p_phase_idle;
        @(posedge sys_clk) disable iff (!reset_n)
        !mod_en_reg |=> phase_reg == BLP_IDLE;
    endproperty
    a_phase_idle: assert property (p_phase_idle) else $error("phase not idle while off");
    property p_ack_answer;
        @(posedge sys_clk) disable iff (!reset_n)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("request not answered");
    property p_duty_boundary;
        @(posedge sys_clk) disable iff (!reset_n)
        mod_en_reg && !per_last |=> $stable(live_reg);
    endproperty
    a_duty_boundary: assert property (p_duty_boundary) else $error("duty changed mid period");
    // A disable inside the eight clocks restarts the prescaler, so it ends the check.
    property p_step_fine;
        @(posedge sys_clk) disable iff (!reset_n || !mod_en_reg)
        mod_en_reg && gran_reg && step_cnt_reg == 8'h00 && $past(step_last) |-> ##7 step_last;
    endproperty
    a_step_fine: assert property (p_step_fine) else $error("fine step not 8 clocks");
    property p_period_wrap;
        @(posedge sys_clk) disable iff (!reset_n)
        per_last && mod_en_reg |=> per_cnt_reg == 17'h00000;
    endproperty
    a_period_wrap: assert property (p_period_wrap) else $error("period did not wrap");
    property p_ack_one;
        @(posedge sys_clk) disable iff (!reset_n) wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
    property p_oe;
        @(posedge sys_clk) disable iff (!reset_n) ##1 util_pin_oe == $past(pin_reg.pin_en);
    endproperty
    a_oe: assert property (p_oe) else $error("pin enable not followed");
    c_enable: cover property (@(posedge sys_clk) disable iff (!reset_n) $rose(mod_en_reg));
    c_wrap: cover property (@(posedge sys_clk) disable iff (!reset_n) per_last);
    c_high: cover property (@(posedge sys_clk) disable iff (!reset_n) $rose(util_pin_o));

endmodule
`default_nettype wire

//--- test/blp_panel_model.sv
// Panel backlight input model that measures pulse high time and period.
`timescale 1ns/10ps
`default_nettype none
module blp_panel_model (
    input wire logic sys_clk,
    input wire logic pin,
    output logic [31:0] high_len,
    output logic [31:0] per_len,
    output logic [7:0] per_cnt
);
    logic [31:0] hc;
    logic [31:0] pc;
    logic pin_q;
    initial begin
        {hc, pc, pin_q, high_len, per_len, per_cnt} = '0;
    end
    // A period is measured from one rising edge of the pin to the next.
    always @(posedge sys_clk) begin
        pin_q <= pin;
        pc <= (pin && !pin_q) ? 32'h1 : pc + 32'h1;
        hc <= !pin ? hc : (!pin_q ? 32'h1 : hc + 32'h1);
        if (pin && !pin_q) begin
            per_len <= pc;
            per_cnt <= per_cnt + 8'h1;
        end
        if (!pin && pin_q) begin
            high_len <= hc;
        end
    end
endmodule
`default_nettype wire

//--- test/tb_backlight_pwm_generator.sv
// Self-checking bench for the backlight PWM generator.
`timescale 1ns/10ps
`default_nettype none
module tb_backlight_pwm_generator;
    import blp_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic wen = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [3:0] sel = 4'hf;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic util_pin_o;
    logic util_pin_oe;
    logic [31:0] high_len;
    logic [31:0] per_len;
    logic [7:0] per_cnt;
    logic [31:0] rd;
    int err_total = 0;
    int cmp_count = 0;
    always #2 sys_clk = ~sys_clk;
    blp_top DUT (.sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(wen), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .util_pin_o(util_pin_o), .util_pin_oe(util_pin_oe));
    blp_panel_model PANEL (.sys_clk(sys_clk), .pin(util_pin_o), .high_len(high_len),
        .per_len(per_len), .per_cnt(per_cnt));
    task automatic end_sim();
        if (err_total == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        wen <= w;
        adr <= a;
        wdat <= d;
        @(posedge sys_clk);
        while (wb_ack_o !== 1'b1 && n < 20) begin
            @(posedge sys_clk);
            n++;
        end
        if (n == 20) begin
            err_total++;
            end_sim();
        end
        rd = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge sys_clk);
    endtask
    // Three new periods guarantee a full period after any pending update.
    task automatic measure(input logic [31:0] hi, input logic [31:0] per);
        int n;
        logic [7:0] start;
        n = 0;
        start = per_cnt;
        while (per_cnt - start < 8'h3 && n < 50000) begin
            @(posedge sys_clk);
            n++;
        end
        if (n == 50000) begin
            err_total++;
            end_sim();
        end
        chk(high_len, hi);
        chk(per_len, per);
    endtask
    task automatic sc_reset_state();
        chk({30'h0, util_pin_o, util_pin_oe}, 32'h0);
        wb(1'b0, BLP_OFF_DATA, 32'h0);
        chk(rd, BLP_DATA_RST);
        wb(1'b1, 4'h2, 32'hffff_ffff);
        wb(1'b0, 4'h2, 32'h0);
        chk(rd, 32'h0);
        wb(1'b0, BLP_OFF_STATUS, 32'h0);
        chk(rd, 32'h0);
    endtask
    task automatic sc_enable_fine();
        wb(1'b1, BLP_OFF_PIN_CTL, 32'h8100_0000);
        chk({31'h0, util_pin_oe}, 32'h1);
        wb(1'b1, BLP_OFF_DATA, {16'd100, 16'd25});
        wb(1'b0, BLP_OFF_DATA, 32'h0);
        chk(rd, {16'd100, 16'd25});
        wb(1'b1, BLP_OFF_MOD_CTL, 32'hc000_0000);
        measure(32'd200, 32'd800);
    endtask
    task automatic sc_duty_update();
        sel <= 4'h3;
        wb(1'b1, BLP_OFF_DATA, {16'hffff, 16'd60});
        sel <= 4'hf;
        wb(1'b0, BLP_OFF_DATA, 32'h0);
        chk(rd, {16'd100, 16'd60});
        measure(32'd480, 32'd800);
    endtask
    task automatic sc_freq_change_coarse();
        wb(1'b1, BLP_OFF_MOD_CTL, 32'h0);
        wb(1'b1, BLP_OFF_PIN_CTL, 32'h8140_0000);
        wb(1'b1, BLP_OFF_DATA, {16'd100, 16'd30});
        chk({31'h0, util_pin_o}, 32'h1);
        wb(1'b1, BLP_OFF_MOD_CTL, 32'h8000_0000);
        measure(32'd8960, 32'd12800);
    endtask
    initial begin
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        sc_reset_state();
        sc_enable_fine();
        sc_duty_update();
        sc_freq_change_coarse();
        end_sim();
    end
endmodule
`default_nettype wire
